// ==== hdl/t2wave_pkg.sv ====
package t2wave_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] OFS_WAVE_OUT_CTRL  = 8'hB0;
  localparam logic [7:0] OFS_CLK_MODE_CTRL  = 8'hB1;
  localparam logic [7:0] OFS_CMP_VALUE_A    = 8'hB4;
  localparam logic [7:0] OFS_CMP_VALUE_B    = 8'hB8;
  localparam logic [7:0] OFS_COUNTER        = 8'hBC;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'hC0;
  localparam logic [7:0] OFS_IRQ_CLEAR      = 8'hC4;
  localparam logic [7:0] OFS_IRQ_ENABLE     = 8'hC8;
  localparam logic [7:0] OFS_PIN_STATUS     = 8'hCC;

  // field positions
  localparam int POS_CHAN_A_ACTION = 6;
  localparam int POS_CHAN_B_ACTION = 4;
  localparam int POS_WAVE_LOW      = 0;
  localparam int POS_WAVE_TOP_BIT  = 3;
  localparam int POS_CLK_RUN       = 0;

  // writable masks; reserved bits are never stored
  localparam logic [7:0] MASK_WAVE_OUT_CTRL = 8'hF3;
  localparam logic [7:0] MASK_CLK_MODE_CTRL = 8'h09;

  // reset values
  localparam logic [7:0] RST_WAVE_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP_VALUE     = 8'h00;
  localparam logic [7:0] RST_COUNTER       = 8'h00;
  localparam logic [2:0] RST_IRQ           = 3'h0;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // interrupt status bits
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_MATCH_A  = 1;
  localparam int IRQ_MATCH_B  = 2;

  typedef enum logic [2:0] {
    WM_NORMAL, WM_PC_FF, WM_CLEAR_ON_MATCH, WM_FAST_FF,
    WM_RSVD4, WM_PC_CMPA, WM_RSVD6, WM_FAST_CMPA
  } t2w_mode_t;

  typedef enum {
    T2W_CLEAN, T2W_NORMAL_UP, T2W_PC_UP, T2W_PC_DOWN
  } t2w_dir_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } t2w_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } t2w_apb_rsp_t;

endpackage

// ==== hdl/t2wave_top.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - A nonzero action field lets that channel's compare output take the pin, except PWM code 01, which takes it only on channel A with the top mode bit set.
// - Non-PWM actions are 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 10 clears on match and sets at bottom; 11 is the inverse.
// - In PWM, channel A code 01 toggles on match only with the top mode bit set.
// - Phase correct 10 clears on up match, sets on down match; 11 inverse.
// - Fast PWM with compare equal to top and upper bit set acts at bottom only.
// - Phase correct with compare equal to top and upper bit set acts at top.
// - Bits 3:2 of the first control register read zero and are not writable.
// - The mode code joins the two low bits and one bit of the second register.
// - Codes pick normal, phase correct, clear-on-match, fast PWM; 4 and 6 reserved.
// - Compare reload and overflow flag timing follow the mode code.
// - The top mode bit sits at bit 3 of the second control register.
module t2wave_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire t2wave_pkg::t2w_apb_req_t i_apb,
  output      t2wave_pkg::t2w_apb_rsp_t o_apb,
  output      logic                    o_compare_out_a,
  output      logic                    o_compare_out_b,
  output      logic                    o_override_a,
  output      logic                    o_override_b,
  output      logic                    o_irq
);

  logic [7:0] wave_ctrl;
  logic [7:0] clk_ctrl;
  logic [7:0] cmp_buf [2];
  logic [7:0] cmp_act [2];
  logic [7:0] counter;
  logic       count_down;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [1:0] pin_level;
  logic [1:0] next_pin_level;
  logic [31:0] rdata;
  logic [2:0] irq_event;

  t2wave_pkg::t2w_mode_t mode;
  logic [1:0] action [2];
  logic       is_pwm;
  logic       is_fast;
  logic       is_pc;
  logic       top_from_a;
  logic [7:0] top_value;
  logic       at_top;
  logic       at_bottom;
  logic       running;
  logic       wr_en;
  logic       rd_en;

  assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign rd_en = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;

  // three-bit mode code from both control registers
  assign mode = t2wave_pkg::t2w_mode_t'({clk_ctrl[t2wave_pkg::POS_WAVE_TOP_BIT],
    wave_ctrl[t2wave_pkg::POS_WAVE_LOW +: 2]});
  assign action[0] = wave_ctrl[t2wave_pkg::POS_CHAN_A_ACTION +: 2];
  assign action[1] = wave_ctrl[t2wave_pkg::POS_CHAN_B_ACTION +: 2];
  assign running = clk_ctrl[t2wave_pkg::POS_CLK_RUN];

  assign is_fast = (mode == t2wave_pkg::WM_FAST_FF) ||
                   (mode == t2wave_pkg::WM_FAST_CMPA);
  assign is_pc = (mode == t2wave_pkg::WM_PC_FF) ||
                 (mode == t2wave_pkg::WM_PC_CMPA);
  assign is_pwm = is_fast | is_pc;
  assign top_from_a = (mode == t2wave_pkg::WM_CLEAR_ON_MATCH) ||
                      (mode == t2wave_pkg::WM_PC_CMPA) ||
                      (mode == t2wave_pkg::WM_FAST_CMPA);
  assign top_value = top_from_a ? cmp_act[0] : t2wave_pkg::CNT_MAX;
  assign at_top = (counter == top_value);
  assign at_bottom = (counter == t2wave_pkg::CNT_BOTTOM);

  // control registers; reserved bits masked off on write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_ctrl <= t2wave_pkg::RST_WAVE_OUT_CTRL;
      clk_ctrl  <= t2wave_pkg::RST_CLK_MODE_CTRL;
    end else if (wr_en) begin
      if (i_apb.paddr == t2wave_pkg::OFS_WAVE_OUT_CTRL) begin
        wave_ctrl <= i_apb.pwdata[7:0] &
                     t2wave_pkg::MASK_WAVE_OUT_CTRL;
      end else if (i_apb.paddr == t2wave_pkg::OFS_CLK_MODE_CTRL) begin
        clk_ctrl <= i_apb.pwdata[7:0] & t2wave_pkg::MASK_CLK_MODE_CTRL;
      end
    end
  end

  // compare buffers and active values; reload point follows mode
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    logic reload;
    always_comb begin
      if (is_pc) begin
        reload = at_top & running;
      end else if (is_fast) begin
        reload = at_bottom & running;
      end else begin
        reload = 1'b1;
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cmp_buf[ch] <= t2wave_pkg::RST_CMP_VALUE;
      end else if (wr_en && i_apb.paddr == (ch == 0 ?
          t2wave_pkg::OFS_CMP_VALUE_A : t2wave_pkg::OFS_CMP_VALUE_B)) begin
        cmp_buf[ch] <= i_apb.pwdata[7:0];
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cmp_act[ch] <= t2wave_pkg::RST_CMP_VALUE;
      end else if (reload) begin
        cmp_act[ch] <= cmp_buf[ch];
      end
    end
  end

  // counter: up with wrap at top, or up/down in phase correct
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      counter    <= t2wave_pkg::RST_COUNTER;
      count_down <= 1'b0;
    end else if (wr_en && i_apb.paddr == t2wave_pkg::OFS_COUNTER) begin
      counter <= i_apb.pwdata[7:0];
    end else if (running) begin
      if (is_pc) begin
        if (!count_down && at_top) begin
          count_down <= 1'b1;
          counter    <= counter - 8'h01;
        end else if (count_down && at_bottom) begin
          count_down <= 1'b0;
          counter    <= counter + 8'h01;
        end else if (count_down) begin
          counter <= counter - 8'h01;
        end else begin
          counter <= counter + 8'h01;
        end
      end else begin
        count_down <= 1'b0;
        counter    <= at_top ? t2wave_pkg::CNT_BOTTOM : counter + 8'h01;
      end
    end
  end

  // output waveform per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_out
    logic match;
    logic top_case;
    assign match = running && (counter == cmp_act[ch]);
    // compare at top with upper bit set is handled at the edge instead
    assign top_case = (cmp_act[ch] == top_value) & action[ch][1];
    always_comb begin
      next_pin_level[ch] = pin_level[ch];
      if (!is_pwm) begin
        if (match) begin
          case (action[ch])
            2'h1: next_pin_level[ch] = ~pin_level[ch];
            2'h2: next_pin_level[ch] = 1'b0;
            2'h3: next_pin_level[ch] = 1'b1;
            default: next_pin_level[ch] = pin_level[ch];
          endcase
        end
      end else if (action[ch] == 2'h1) begin
        if (ch == 0 && clk_ctrl[t2wave_pkg::POS_WAVE_TOP_BIT] && match) begin
          next_pin_level[ch] = ~pin_level[ch];
        end
        // channel b code 01 reserved: pin stays disconnected
      end else if (action[ch][1] && running) begin
        if (is_fast) begin
          if (at_bottom) begin
            next_pin_level[ch] = ~action[ch][0];
          end else if (match && !top_case) begin
            next_pin_level[ch] = action[ch][0];
          end
        end else begin
          if (top_case && at_top) begin
            next_pin_level[ch] = action[ch][0];
          end else if (match && !top_case) begin
            next_pin_level[ch] = count_down ? ~action[ch][0]
                                            : action[ch][0];
          end
        end
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pin_level[ch] <= 1'b0;
      end else begin
        pin_level[ch] <= next_pin_level[ch];
      end
    end
  end

  // pin override; direction bit lives outside, in the port logic
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_override_a    <= 1'b0;
      o_override_b    <= 1'b0;
      o_compare_out_a <= 1'b0;
      o_compare_out_b <= 1'b0;
    end else begin
      // pwm code 01 only reaches the pin with the top mode bit set
      o_override_a <= |action[0] &&
                      !(is_pwm && action[0] == 2'h1 &&
                        !clk_ctrl[t2wave_pkg::POS_WAVE_TOP_BIT]);
      // reserved code in pwm modes keeps b off the pin
      o_override_b <= |action[1] &&
                      !(is_pwm && action[1] == 2'h1);
      o_compare_out_a <= next_pin_level[0];
      o_compare_out_b <= next_pin_level[1];
    end
  end

  // overflow event point per mode
  always_comb begin
    irq_event = '0;
    if (running) begin
      case (mode)
        t2wave_pkg::WM_PC_FF,
        t2wave_pkg::WM_PC_CMPA:
          irq_event[t2wave_pkg::IRQ_OVERFLOW] = at_bottom & count_down;
        t2wave_pkg::WM_FAST_CMPA:
          irq_event[t2wave_pkg::IRQ_OVERFLOW] = at_top;
        default:
          irq_event[t2wave_pkg::IRQ_OVERFLOW] =
            (counter == t2wave_pkg::CNT_MAX);
      endcase
      irq_event[t2wave_pkg::IRQ_MATCH_A] = (counter == cmp_act[0]);
      irq_event[t2wave_pkg::IRQ_MATCH_B] = (counter == cmp_act[1]);
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= t2wave_pkg::RST_IRQ;
      irq_enable <= t2wave_pkg::RST_IRQ;
    end else begin
      if (wr_en && i_apb.paddr == t2wave_pkg::OFS_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~i_apb.pwdata[2:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      if (wr_en && i_apb.paddr == t2wave_pkg::OFS_IRQ_ENABLE) begin
        irq_enable <= i_apb.pwdata[2:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_enable);
    end
  end

  // read mux
  always_comb begin
    rdata = '0;
    if (i_apb.paddr == t2wave_pkg::OFS_WAVE_OUT_CTRL) begin
      rdata[7:0] = wave_ctrl;
    end else if (i_apb.paddr == t2wave_pkg::OFS_CLK_MODE_CTRL) begin
      rdata[7:0] = clk_ctrl;
    end else if (i_apb.paddr == t2wave_pkg::OFS_CMP_VALUE_A) begin
      rdata[7:0] = cmp_buf[0];
    end else if (i_apb.paddr == t2wave_pkg::OFS_CMP_VALUE_B) begin
      rdata[7:0] = cmp_buf[1];
    end else if (i_apb.paddr == t2wave_pkg::OFS_COUNTER) begin
      rdata[7:0] = counter;
    end else if (i_apb.paddr == t2wave_pkg::OFS_IRQ_STATUS) begin
      rdata[2:0] = irq_status;
    end else if (i_apb.paddr == t2wave_pkg::OFS_IRQ_ENABLE) begin
      rdata[2:0] = irq_enable;
    end else if (i_apb.paddr == t2wave_pkg::OFS_PIN_STATUS) begin
      rdata[1:0] = pin_level;
    end
  end

  // no wait state: data latched in setup, ready in the first access cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_apb <= '0;
    end else begin
      o_apb.pready  <= i_apb.psel & ~i_apb.penable;
      o_apb.pslverr <= 1'b0;
      if (rd_en) begin
        o_apb.prdata <= rdata;
      end
    end
  end

endmodule

// ==== verification/t2wave_monitor.sv ====
`timescale 1ns/1ps
module t2wave_monitor (
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  input wire t2wave_pkg::t2w_apb_req_t i_apb,
  input wire t2wave_pkg::t2w_apb_rsp_t o_apb,
  input wire logic                     o_compare_out_a,
  input wire logic                     o_compare_out_b,
  input wire logic                     o_override_a,
  input wire logic                     o_override_b,
  input wire logic                     o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic setup;
  logic wr_ctl;
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_ctl = i_apb.psel && i_apb.penable && i_apb.pwrite
                  && i_apb.paddr == t2wave_pkg::OFS_WAVE_OUT_CTRL;
  a_ready_after_setup: assert property (setup |=> o_apb.pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property
    (o_apb.pready |-> i_apb.psel && i_apb.penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready too long");
  a_no_slave_error: assert property (!o_apb.pslverr)
    else $error("slave error raised");
  a_rsvd_read_zero: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == t2wave_pkg::OFS_WAVE_OUT_CTRL
    |=> o_apb.prdata[3:2] == 2'b00) else $error("reserved bits nonzero");
  a_override_a_on: assert property (
    wr_ctl && i_apb.pwdata[7] |-> ##2 o_override_a)
    else $error("channel a not on pin");
  a_override_b_on: assert property (
    wr_ctl && i_apb.pwdata[5] |-> ##2 o_override_b)
    else $error("channel b not on pin");
  a_override_off: assert property (
    wr_ctl && i_apb.pwdata[7:4] == 4'h0
    |-> ##2 !o_override_a && !o_override_b) else $error("pin not freed");
  a_reset_quiet: assert property (
    $rose(i_rst_n) |-> !o_override_a && !o_override_b && !o_irq)
    else $error("outputs active after reset");
  c_irq: cover property ($rose(o_irq));
  c_toggle_a: cover property ($changed(o_compare_out_a));
  c_override_b: cover property ($rose(o_override_b));
endmodule

bind t2wave_top t2wave_monitor i_mon (
  .i_clk, .i_rst_n, .i_apb, .o_apb, .o_compare_out_a, .o_compare_out_b,
  .o_override_a, .o_override_b, .o_irq
);

// ==== verification/t2wave_pin.sv ====
`timescale 1ns/1ps
module t2wave_pin (
  input  wire logic i_dir,
  input  wire logic i_port,
  input  wire logic i_ovr,
  input  wire logic i_oc,
  output      logic o_pin
);
  // undriven pin settles to the pull-up
  always_comb begin
    if (!i_dir) begin
      o_pin = 1'b1;
    end else begin
      o_pin = i_ovr ? i_oc : i_port;
    end
  end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] CTL = t2wave_pkg::OFS_WAVE_OUT_CTRL;
  localparam logic [7:0] MOD = t2wave_pkg::OFS_CLK_MODE_CTRL;
  localparam logic [7:0] CA  = t2wave_pkg::OFS_CMP_VALUE_A;
  localparam logic [7:0] IST = t2wave_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] ICL = t2wave_pkg::OFS_IRQ_CLEAR;
  localparam logic [7:0] IEN = t2wave_pkg::OFS_IRQ_ENABLE;
  logic                     clk = 1'b0;
  logic                     rst_n;
  t2wave_pkg::t2w_apb_req_t req;
  t2wave_pkg::t2w_apb_rsp_t rsp;
  logic                     oca, ocb, ova, ovb, irq, pin_a, pin_dir;
  logic [7:0]               q;
  int                       err_count, num_checks, cyc, h1, h2, c;
  always #20 clk = ~clk;
  t2wave_top i_t2wave_top (.i_clk(clk), .i_rst_n(rst_n), .i_apb(req),
    .o_apb(rsp), .o_compare_out_a(oca), .o_compare_out_b(ocb),
    .o_override_a(ova), .o_override_b(ovb), .o_irq(irq));
  t2wave_pin i_pin (.i_dir(pin_dir), .i_port(1'b0), .i_ovr(ova),
    .i_oc(oca), .o_pin(pin_a));
  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata[7:0];
    req <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (((s != 0 ? irq : oca) !== v) && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(s != 0 ? irq : oca, v);
  endtask
  // settle for 600 cycles, over one period in every mode, so the buffered compare value is live
  task automatic hi(input int n, output int h);
    repeat (600) @(posedge clk);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      h += (oca === 1'b1);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    pin_dir = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTL, 8'hFF, 8'h00);
    rd(MOD, 8'hFF, 8'h00);
    chk({ova, ovb, irq}, 3'h0);
    chk(pin_a, 1'b1);
    pin_dir <= 1'b1;
    wr(CTL, 8'hFF);
    rd(CTL, 8'hFF, 8'hF3);
    wr(MOD, 8'hFF);
    rd(MOD, 8'hFF, 8'h09);
    wr(MOD, 8'h00);
    for (c = 0; c < 4; c++) begin
      wr(CTL, 8'(c * 8'h50));
      chk({ova, ovb}, {2{c != 0}});
    end
    for (c = 1; c < 4; c += 2) begin
      wr(CTL, 8'(8'h50 + c));
      chk({ova, ovb}, 2'b00);
      wr(MOD, 8'h08);
      chk({ova, ovb}, 2'b10);
      wr(MOD, 8'h00);
    end
    wr(CA, 8'h10);
    wr(MOD, 8'h01);
    wr(CTL, 8'hF0);
    wt(0, 1'b1);
    wr(CTL, 8'hB0);
    wt(0, 1'b0);
    chk(ocb, 1'b1);
    wr(CTL, 8'h40);
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk(pin_a, oca);
    wr(IEN, 8'h01);
    wt(1, 1'b1);
    wr(MOD, 8'h00);
    wr(IEN, 8'h00);
    chk(irq, 1'b0);
    rd(IST, 8'h01, 8'h01);
    wr(IEN, 8'h01);
    chk(irq, 1'b1);
    wr(ICL, 8'h07);
    chk(irq, 1'b0);
    rd(IST, 8'h07, 8'h00);
    rd(8'hF0, 8'hFF, 8'h00);
    // off-centre duty so the two polarities differ
    wr(CA, 8'hC0);
    wr(CTL, 8'h83);
    wr(MOD, 8'h01);
    hi(512, h1);
    wr(CTL, 8'hC3);
    hi(512, h2);
    chk(h1 + h2, 512);
    chk(h1 > h2, 1'b1);
    wr(CA, 8'hFF);
    hi(512, h1);
    chk(h1, 0);
    wr(CTL, 8'h83);
    hi(512, h1);
    chk(h1, 512);
    wr(CA, 8'h40);
    wr(CTL, 8'h81);
    hi(1020, h1);
    wr(CTL, 8'hC1);
    hi(1020, h2);
    chk(h1 + h2, 1020);
    chk(h1 < h2, 1'b1);
    wr(CA, 8'hFF);
    hi(1020, h1);
    chk(h1, 1020);
    report_and_stop();
  end
endmodule
